/* File: hdl/spse_cfg.svh */
`ifndef SPSE_CFG_SVH
`define SPSE_CFG_SVH
// Word offsets within the inbound status block
`define SPSE_OFS_PHASE        8'h21
`define SPSE_OFS_CHARS        8'h22
`define SPSE_OFS_BLOCKS       8'h23
`define SPSE_OFS_FAULT        8'h24
`define SPSE_BLK_WORDS        4
// Fault flag bit positions
`define SPSE_FB_TERM          0
`define SPSE_FB_BAUD          1
`define SPSE_FB_PARITY        2
`define SPSE_FB_WORD_LEN      3
`define SPSE_FB_STOP          4
`define SPSE_FB_HANDSHAKE     5
`define SPSE_FB_TERM_CNT      6
`define SPSE_FB_PKT_LEN       7
`define SPSE_FB_RX_TMO        8
`define SPSE_FB_ICD           9
`define SPSE_FB_WR_TMO        10
`define SPSE_FB_OVERRUN       15
// Termination type bits selecting each receive end condition
`define SPSE_TT_STR_BIT       0
`define SPSE_TT_PKT_BIT       1
`define SPSE_TT_TMO_BIT       2
// Configuration limits and fallbacks
`define SPSE_TERM_MAX         16'h000f
`define SPSE_PARITY_MAX       16'h0004
`define SPSE_WLEN_MIN         16'h0005
`define SPSE_WLEN_MAX         16'h0008
`define SPSE_STOP_MIN         16'h0001
`define SPSE_STOP_MAX         16'h0002
`define SPSE_HS_MAX           16'h0003
`define SPSE_TCNT_MIN         16'h0001
`define SPSE_TCNT_MAX         16'h000c
`define SPSE_PKT_MIN          16'h0001
`define SPSE_PKT_MAX          16'h1000
`define SPSE_BAUD_FALLBACK    32'h0000_2580
`define SPSE_WTMO_FALLBACK    16'h1388
`define SPSE_RST_WORD         16'h0000
// Transmit phase codes
`define SPSE_PH_IDLE          16'h0000
`define SPSE_PH_RTS_ON        16'h0001
`define SPSE_PH_RTS_TMO       16'h0002
`define SPSE_PH_SEND          16'h0003
`define SPSE_PH_RTS_WAIT      16'h0004
`define SPSE_PH_RTS_OFF       16'h0005
`define SPSE_PH_ICD0          16'h001e
`define SPSE_PH_ICD1          16'h001f
`define SPSE_PH_ICD2          16'h0020
`define SPSE_PH_MDLY0         16'h0064
`define SPSE_PH_MDLY1         16'h0065
// Timing
`define SPSE_CLK_NS           25
`define SPSE_MS_NS            1000000
`endif

/* File: hdl/spse_pkg.sv */
package spse_pkg;
    typedef struct packed {
        logic [15:0] term_type;
        logic [31:0] baud;
        logic [15:0] parity;
        logic [15:0] word_len;
        logic [15:0] stop_bits;
        logic [15:0] handshake;
        logic [15:0] term_cnt;
        logic [15:0] pkt_len;
        logic [15:0] rx_tmo;
        logic [15:0] icd;
        logic [15:0] wr_tmo;
        logic [15:0] msg_dly;
    } spse_cfg_t;

    typedef struct packed {
        logic [3:0]  term_type;
        logic [31:0] baud;
        logic [2:0]  parity;
        logic [3:0]  word_len;
        logic [1:0]  stop_bits;
        logic [1:0]  handshake;
        logic        term_str_en;
        logic        pkt_len_en;
        logic        rx_tmo_en;
        logic        icd_en;
        logic [15:0] wr_tmo;
    } spse_eff_t;

    typedef struct packed {
        logic [7:0]  offset;
        logic [15:0] data;
    } spse_word_t;

    typedef enum logic [10:0] {
        SPSE_IDLE     = 11'h001,
        SPSE_MDLY0    = 11'h002,
        SPSE_MDLY1    = 11'h004,
        SPSE_RTS_ON   = 11'h008,
        SPSE_RTS_TMO  = 11'h010,
        SPSE_SEND     = 11'h020,
        SPSE_ICD0     = 11'h040,
        SPSE_ICD1     = 11'h080,
        SPSE_ICD2     = 11'h100,
        SPSE_RTS_WAIT = 11'h200,
        SPSE_RTS_OFF  = 11'h400
    } spse_state_t;
endpackage

/* File: hdl/spse_status.sv */
// Functional notes
// - Report transmit sequencer phase codes zero to five
// - Delay phases report 30-32 and 100-101
// - Count transmitted characters at word 34
// - Count transmitted blocks at word 35
// - Bad termination type: flag, use stream
// - Bad baud rate: flag, run 9600
// - Parity above four: flag, use none
// - Word length outside 5-8: flag, use 8
// - Stop bits not 1/2: flag, use 1
// - Handshake above three: flag, use none
// - Bad termination count: flag, drop string end
// - Bad packet length: flag, drop length end
// - Zero receive timeout: flag, drop timeout end
// - Zero intercharacter delay: flag, skip delay
// - Zero write timeout: flag, use 5000 ms
// - Receive overrun of read blocks sets bit 15
// - Every read block carries all port words
`timescale 1ns/1ps
`include "spse_cfg.svh"
module spse_status #(
    parameter int MS_CYC = `SPSE_MS_NS / `SPSE_CLK_NS
) (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    input  wire logic                cfg_load_i,
    input  wire spse_pkg::spse_cfg_t cfg_i,
    output spse_pkg::spse_eff_t      eff_cfg_o,
    input  wire logic                tx_msg_valid_i,
    input  wire logic [15:0]         tx_msg_len_i,
    output logic                     tx_msg_ready_o,
    output logic                     uart_load_o,
    input  wire logic                uart_ready_i,
    input  wire logic                uart_idle_i,
    input  wire logic                cts_i,
    output logic                     rts_o,
    input  wire logic                rx_block_i,
    output logic                     rx_drop_o,
    input  wire logic                blk_read_i,
    output logic                     blk_valid_o,
    output logic                     blk_last_o,
    output spse_pkg::spse_word_t     blk_word_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    spse_pkg::spse_state_t state;
    spse_pkg::spse_state_t next_state;
    spse_pkg::spse_eff_t   next_eff;
    spse_pkg::spse_cfg_t   cfg_q;
    logic [10:0]           cfg_fault;
    logic [10:0]           next_cfg_fault;
    logic                  overrun;
    logic                  rx_pending;
    logic [15:0]           fault_flags;
    logic [15:0]           transmit_phase;
    logic [15:0]           sent_char_total;
    logic [15:0]           sent_block_total;
    logic [15:0]           chars_left;
    logic [15:0]           tmr;
    logic [31:0]           pre;
    logic                  tmr_load;
    logic [15:0]           tmr_val;
    logic                  char_done;
    logic                  blk_busy;
    logic [1:0]            blk_idx;
    logic                  blk_end;
    logic [15:0]           snap [`SPSE_BLK_WORDS];
    logic [7:0]            snap_ofs [`SPSE_BLK_WORDS];

    function automatic logic baud_ok(input logic [31:0] b);
        case (b)
            32'h0000_012c, 32'h0000_0258, 32'h0000_04b0, 32'h0000_0960,
            32'h0000_12c0, 32'h0000_2580, 32'h0000_4b00, 32'h0000_9600,
            32'h0000_e100, 32'h0001_c200: baud_ok = 1'b1;
            default:                      baud_ok = 1'b0;
        endcase
    endfunction

    // Evaluate one configuration into its effective settings and faults
    always_comb
    begin
        next_cfg_fault = '0;
        next_eff.term_type = cfg_i.term_type[3:0];
        if (cfg_i.term_type > `SPSE_TERM_MAX)
        begin
            next_cfg_fault[`SPSE_FB_TERM] = 1'b1;
            next_eff.term_type = 4'h0;
        end
        next_eff.baud = cfg_i.baud;
        if (!baud_ok(cfg_i.baud))
        begin
            next_cfg_fault[`SPSE_FB_BAUD] = 1'b1;
            next_eff.baud = `SPSE_BAUD_FALLBACK;
        end
        next_eff.parity = cfg_i.parity[2:0];
        if (cfg_i.parity > `SPSE_PARITY_MAX)
        begin
            next_cfg_fault[`SPSE_FB_PARITY] = 1'b1;
            next_eff.parity = 3'h0;
        end
        next_eff.word_len = cfg_i.word_len[3:0];
        if (cfg_i.word_len < `SPSE_WLEN_MIN || cfg_i.word_len > `SPSE_WLEN_MAX)
        begin
            next_cfg_fault[`SPSE_FB_WORD_LEN] = 1'b1;
            next_eff.word_len = 4'h8;
        end
        next_eff.stop_bits = cfg_i.stop_bits[1:0];
        if (cfg_i.stop_bits < `SPSE_STOP_MIN ||
            cfg_i.stop_bits > `SPSE_STOP_MAX)
        begin
            next_cfg_fault[`SPSE_FB_STOP] = 1'b1;
            next_eff.stop_bits = 2'h1;
        end
        next_eff.handshake = cfg_i.handshake[1:0];
        if (cfg_i.handshake > `SPSE_HS_MAX)
        begin
            next_cfg_fault[`SPSE_FB_HANDSHAKE] = 1'b1;
            next_eff.handshake = 2'h0;
        end
        // String and length checks follow the fallback type, not the raw one; the timeout check ignores type
        next_eff.term_str_en = next_eff.term_type[`SPSE_TT_STR_BIT];
        if (next_eff.term_str_en && (cfg_i.term_cnt < `SPSE_TCNT_MIN ||
            cfg_i.term_cnt > `SPSE_TCNT_MAX))
        begin
            next_cfg_fault[`SPSE_FB_TERM_CNT] = 1'b1;
            next_eff.term_str_en = 1'b0;
        end
        next_eff.pkt_len_en = next_eff.term_type[`SPSE_TT_PKT_BIT];
        if (next_eff.pkt_len_en && (cfg_i.pkt_len < `SPSE_PKT_MIN ||
            cfg_i.pkt_len > `SPSE_PKT_MAX))
        begin
            next_cfg_fault[`SPSE_FB_PKT_LEN] = 1'b1;
            next_eff.pkt_len_en = 1'b0;
        end
        next_eff.rx_tmo_en = next_eff.term_type[`SPSE_TT_TMO_BIT];
        if (cfg_i.rx_tmo == `SPSE_RST_WORD)
        begin
            next_cfg_fault[`SPSE_FB_RX_TMO] = 1'b1;
            next_eff.rx_tmo_en = 1'b0;
        end
        next_eff.icd_en = (cfg_i.icd != `SPSE_RST_WORD);
        next_cfg_fault[`SPSE_FB_ICD] = !next_eff.icd_en;
        next_eff.wr_tmo = cfg_i.wr_tmo;
        if (cfg_i.wr_tmo == `SPSE_RST_WORD)
        begin
            next_cfg_fault[`SPSE_FB_WR_TMO] = 1'b1;
            next_eff.wr_tmo = `SPSE_WTMO_FALLBACK;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_fault <= '0;
            cfg_q     <= '0;
            eff_cfg_o <= '{term_type: 4'h0, baud: `SPSE_BAUD_FALLBACK,
                           parity: 3'h0, word_len: 4'h8, stop_bits: 2'h1,
                           handshake: 2'h0, term_str_en: 1'b0,
                           pkt_len_en: 1'b0, rx_tmo_en: 1'b0, icd_en: 1'b0,
                           wr_tmo: `SPSE_WTMO_FALLBACK};
        end
        else if (cfg_load_i)
        begin
            cfg_fault <= next_cfg_fault;
            cfg_q     <= cfg_i;
            eff_cfg_o <= next_eff;
        end
    end

    // A new receive block while the last is still unread is lost
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_pending <= 1'b0;
            overrun    <= 1'b0;
            rx_drop_o  <= 1'b0;
        end
        else
        begin
            rx_drop_o <= rx_block_i && rx_pending && !blk_end;
            if (rx_block_i)
                rx_pending <= 1'b1;
            else if (blk_end)
                rx_pending <= 1'b0;
            // Set wins over the clear done by a configuration load
            if (rx_block_i && rx_pending && !blk_end)
                overrun <= 1'b1;
            else if (cfg_load_i)
                overrun <= 1'b0;
        end
    end

    assign fault_flags = {overrun, 4'h0, cfg_fault};

    always_comb
    begin
        unique case (state)
            spse_pkg::SPSE_IDLE:     transmit_phase = `SPSE_PH_IDLE;
            spse_pkg::SPSE_RTS_ON:   transmit_phase = `SPSE_PH_RTS_ON;
            spse_pkg::SPSE_RTS_TMO:  transmit_phase = `SPSE_PH_RTS_TMO;
            spse_pkg::SPSE_SEND:     transmit_phase = `SPSE_PH_SEND;
            spse_pkg::SPSE_RTS_WAIT: transmit_phase = `SPSE_PH_RTS_WAIT;
            spse_pkg::SPSE_RTS_OFF:  transmit_phase = `SPSE_PH_RTS_OFF;
            spse_pkg::SPSE_ICD0:     transmit_phase = `SPSE_PH_ICD0;
            spse_pkg::SPSE_ICD1:     transmit_phase = `SPSE_PH_ICD1;
            spse_pkg::SPSE_ICD2:     transmit_phase = `SPSE_PH_ICD2;
            spse_pkg::SPSE_MDLY0:    transmit_phase = `SPSE_PH_MDLY0;
            spse_pkg::SPSE_MDLY1:    transmit_phase = `SPSE_PH_MDLY1;
            default:                 transmit_phase = `SPSE_PH_IDLE;
        endcase
    end

    assign tx_msg_ready_o = (state == spse_pkg::SPSE_IDLE);
    assign uart_load_o    = (state == spse_pkg::SPSE_SEND);
    assign char_done      = uart_load_o && uart_ready_i;
    assign rts_o = (eff_cfg_o.handshake != 2'h0) &&
                   !(state inside {spse_pkg::SPSE_IDLE, spse_pkg::SPSE_MDLY0,
                     spse_pkg::SPSE_MDLY1, spse_pkg::SPSE_RTS_TMO,
                     spse_pkg::SPSE_RTS_OFF});

    always_comb
    begin
        next_state = state;
        unique case (state)
            spse_pkg::SPSE_IDLE:
                if (tx_msg_valid_i && tx_msg_len_i != `SPSE_RST_WORD)
                begin
                    if (cfg_q.msg_dly != `SPSE_RST_WORD)
                        next_state = spse_pkg::SPSE_MDLY0;
                    else if (eff_cfg_o.handshake != 2'h0)
                        next_state = spse_pkg::SPSE_RTS_ON;
                    else
                        next_state = spse_pkg::SPSE_SEND;
                end
            spse_pkg::SPSE_MDLY0:
                next_state = spse_pkg::SPSE_MDLY1;
            spse_pkg::SPSE_MDLY1:
                if (tmr == `SPSE_RST_WORD)
                    next_state = (eff_cfg_o.handshake != 2'h0) ?
                                 spse_pkg::SPSE_RTS_ON : spse_pkg::SPSE_SEND;
            spse_pkg::SPSE_RTS_ON:
                if (cts_i)
                    next_state = spse_pkg::SPSE_SEND;
                else if (tmr == `SPSE_RST_WORD)
                    next_state = spse_pkg::SPSE_RTS_TMO;
            spse_pkg::SPSE_RTS_TMO:
                next_state = spse_pkg::SPSE_IDLE;
            spse_pkg::SPSE_SEND:
                if (char_done)
                begin
                    if (chars_left == 16'h0001)
                        next_state = spse_pkg::SPSE_RTS_WAIT;
                    else if (eff_cfg_o.icd_en)
                        next_state = spse_pkg::SPSE_ICD0;
                end
            spse_pkg::SPSE_ICD0:
                next_state = spse_pkg::SPSE_ICD1;
            spse_pkg::SPSE_ICD1:
                if (tmr == `SPSE_RST_WORD)
                    next_state = spse_pkg::SPSE_ICD2;
            spse_pkg::SPSE_ICD2:
                next_state = spse_pkg::SPSE_SEND;
            spse_pkg::SPSE_RTS_WAIT:
                if (uart_idle_i)
                    next_state = spse_pkg::SPSE_RTS_OFF;
            spse_pkg::SPSE_RTS_OFF:
                next_state = spse_pkg::SPSE_IDLE;
            default:
                next_state = spse_pkg::SPSE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            state <= spse_pkg::SPSE_IDLE;
        else
            state <= next_state;
    end

    // Millisecond timer is armed on entry to SPSE_MDLY1, SPSE_ICD1 and SPSE_RTS_ON, not SPSE_RTS_WAIT
    assign tmr_load = (next_state != state) &&
                      (next_state inside {spse_pkg::SPSE_MDLY1,
                       spse_pkg::SPSE_ICD1, spse_pkg::SPSE_RTS_ON});
    assign tmr_val  = (next_state == spse_pkg::SPSE_MDLY1) ? cfg_q.msg_dly :
                      (next_state == spse_pkg::SPSE_ICD1) ? cfg_q.icd :
                      eff_cfg_o.wr_tmo;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tmr <= `SPSE_RST_WORD;
            pre <= 32'h0000_0000;
        end
        else if (tmr_load)
        begin
            tmr <= tmr_val;
            pre <= 32'h0000_0000;
        end
        else if (tmr != `SPSE_RST_WORD)
        begin
            if (pre == 32'(MS_CYC - 1))
            begin
                pre <= 32'h0000_0000;
                tmr <= tmr - 16'h0001;
            end
            else
                pre <= pre + 32'h0000_0001;
        end
    end

    // Counters wrap at 16 bits, as the host expects of a status word
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sent_char_total  <= `SPSE_RST_WORD;
            sent_block_total <= `SPSE_RST_WORD;
            chars_left       <= `SPSE_RST_WORD;
        end
        else
        begin
            if (tx_msg_ready_o && tx_msg_valid_i)
                chars_left <= tx_msg_len_i;
            else if (char_done)
                chars_left <= chars_left - 16'h0001;
            if (char_done)
                sent_char_total <= sent_char_total + 16'h0001;
            if (state == spse_pkg::SPSE_RTS_OFF)
                sent_block_total <= sent_block_total + 16'h0001;
        end
    end

    // The words are frozen at the request so one block is coherent
    assign blk_end = blk_busy && (blk_idx == 2'(`SPSE_BLK_WORDS - 1));
    assign snap_ofs[0] = `SPSE_OFS_PHASE;
    assign snap_ofs[1] = `SPSE_OFS_CHARS;
    assign snap_ofs[2] = `SPSE_OFS_BLOCKS;
    assign snap_ofs[3] = `SPSE_OFS_FAULT;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            blk_busy    <= 1'b0;
            blk_idx     <= 2'h0;
            blk_valid_o <= 1'b0;
            blk_last_o  <= 1'b0;
            blk_word_o  <= '0;
            for (int i = 0; i < `SPSE_BLK_WORDS; i++)
                snap[i] <= `SPSE_RST_WORD;
        end
        else
        begin
            blk_valid_o <= blk_busy;
            blk_last_o  <= blk_end;
            if (blk_busy)
                blk_word_o <= '{offset: snap_ofs[blk_idx],
                                data: snap[blk_idx]};
            if (blk_read_i && !blk_busy)
            begin
                blk_busy <= 1'b1;
                blk_idx  <= 2'h0;
                snap[0]  <= transmit_phase;
                snap[1]  <= sent_char_total;
                snap[2]  <= sent_block_total;
                snap[3]  <= fault_flags;
            end
            else if (blk_busy)
            begin
                blk_idx <= blk_idx + 2'h1;
                if (blk_end)
                    blk_busy <= 1'b0;
            end
        end
    end

    AST_SEND_DIRECT: assert property (tx_msg_ready_o && tx_msg_valid_i &&
        tx_msg_len_i != 16'h0000 && cfg_q.msg_dly == 16'h0000 &&
        eff_cfg_o.handshake == 2'h0 |=> transmit_phase == 16'h0003)
        else $error("direct send did not report phase 3");
    AST_ICD_SEQ: assert property (transmit_phase == 16'h001e |=>
        transmit_phase == 16'h001f)
        else $error("delay phase 30 not followed by 31");
    AST_CHAR_CNT: assert property (char_done |=>
        sent_char_total == $past(sent_char_total) + 16'h0001)
        else $error("character count missed a character");
    AST_BLK_CNT: assert property (transmit_phase == 16'h0005 ##1
        transmit_phase == 16'h0000 |-> sent_block_total ==
        $past(sent_block_total) + 16'h0001)
        else $error("block count missed a block");
    AST_TERM_FB: assert property (cfg_load_i &&
        cfg_i.term_type > 16'h000f |=> fault_flags[0] &&
        eff_cfg_o.term_type == 4'h0)
        else $error("bad termination type not handled");
    AST_BAUD_FB: assert property (cfg_load_i && !baud_ok(cfg_i.baud) |=>
        fault_flags[1] && eff_cfg_o.baud == 32'h0000_2580)
        else $error("bad baud not handled");
    AST_PARITY_FB: assert property (cfg_load_i && cfg_i.parity > 16'h0004
        |=> fault_flags[2] && eff_cfg_o.parity == 3'h0)
        else $error("bad parity not handled");
    AST_WLEN_FB: assert property (cfg_load_i && cfg_i.word_len < 16'h0005
        |=> fault_flags[3] && eff_cfg_o.word_len == 4'h8)
        else $error("bad word length not handled");
    AST_STOP_FB: assert property (cfg_load_i &&
        cfg_i.stop_bits == 16'h0000 |=> fault_flags[4] &&
        eff_cfg_o.stop_bits == 2'h1)
        else $error("bad stop count not handled");
    AST_HS_FB: assert property (cfg_load_i && cfg_i.handshake > 16'h0003
        |=> fault_flags[5] && !rts_o)
        else $error("bad handshake not handled");
    AST_WTMO_FB: assert property (cfg_load_i && cfg_i.wr_tmo == 16'h0000
        |=> fault_flags[10] && eff_cfg_o.wr_tmo == 16'h1388)
        else $error("zero write timeout not handled");
    AST_ICD_OFF: assert property (fault_flags[9] |->
        !(state inside {spse_pkg::SPSE_ICD0, spse_pkg::SPSE_ICD1}))
        else $error("delay ran while disabled");
    AST_OVERRUN: assert property (rx_block_i && rx_pending &&
        !blk_end |=> fault_flags[15] && rx_drop_o)
        else $error("receive overrun not flagged");
    AST_BLOCK: assert property (blk_read_i && !blk_busy |=>
        ##1 blk_valid_o && blk_word_o.offset == 8'h21 ##3 blk_last_o)
        else $error("read block incomplete");
    AST_RSVD: assert property (fault_flags[14:11] == 4'h0)
        else $error("unassigned fault bits set");
    AST_HOLD: assert property (!cfg_load_i |=>
        fault_flags[10:0] == $past(fault_flags[10:0]))
        else $error("config faults changed without load");
endmodule // spse_status

/* File: testbench/spse_uart_model.sv */
`timescale 1ns/1ps
module spse_uart_model (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic uart_load_i,
    output logic      uart_ready_o,
    output logic      uart_idle_o
);
    logic [1:0] busy;
    // Slow shifter: one character every other cycle, busy after each
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            uart_ready_o <= 1'b0;
            busy         <= 2'h0;
        end
        else
        begin
            uart_ready_o <= uart_load_i && !uart_ready_o;
            if (uart_load_i && !uart_ready_o)
                busy <= 2'h3;
            else if (busy != 2'h0)
                busy <= busy - 2'h1;
        end
    end
    assign uart_idle_o = (busy == 2'h0) && !uart_load_i;
endmodule // spse_uart_model

/* File: testbench/serial_port_status_and_error_word_test.sv */
`timescale 1ns/1ps
module serial_port_status_and_error_word_test;
    logic clk = 1'b0, rst_i = 1'b1, ld = 1'b0, tv = 1'b0, cts = 1'b0;
    logic rxb = 1'b0, rdq = 1'b0, rdy, idl, trdy, uld, rts, drp, bv, bl;
    logic [15:0] tl = 16'h0000;
    logic [15:0] w [4];
    spse_pkg::spse_cfg_t cfg = '0, g, b;
    spse_pkg::spse_eff_t eff;
    spse_pkg::spse_word_t bw;
    int n_errors = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    spse_status #(.MS_CYC(4)) dut (.clk_sys_i(clk), .rst_i(rst_i),
        .cfg_load_i(ld), .cfg_i(cfg), .eff_cfg_o(eff), .tx_msg_valid_i(tv),
        .tx_msg_len_i(tl), .tx_msg_ready_o(trdy), .uart_load_o(uld),
        .uart_ready_i(rdy), .uart_idle_i(idl), .cts_i(cts), .rts_o(rts),
        .rx_block_i(rxb), .rx_drop_o(drp), .blk_read_i(rdq),
        .blk_valid_o(bv), .blk_last_o(bl), .blk_word_o(bw));
    spse_uart_model uart (.clk_sys_i(clk), .rst_i(rst_i),
        .uart_load_i(uld), .uart_ready_o(rdy), .uart_idle_o(idl));
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, string nm);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task load(input spse_pkg::spse_cfg_t c);
        @(negedge clk) cfg = c;
        ld = 1'b1;
        @(negedge clk) ld = 1'b0;
    endtask
    task rd;
        int i, k;
        @(negedge clk) rdq = 1'b1;
        @(negedge clk) rdq = 1'b0;
        i = 0;
        for (k = 0; k < 8 && i < 4; k++)
        begin
            @(negedge clk);
            if (bv === 1'b1)
            begin
                chk(bw.offset, 8'h21 + i, "offset");
                chk(bl, i == 3, "last");
                w[i] = bw.data;
                i++;
            end
        end
        if (i < 4)
        begin
            n_errors++;
            print_verdict;
        end
    endtask
    task send(input logic [15:0] n, input logic wt);
        int k;
        @(negedge clk) tv = 1'b1;
        tl = n;
        @(negedge clk) tv = 1'b0;
        for (k = 0; wt && k < 300 && trdy !== 1'b1; k++)
            @(negedge clk);
        if (k == 300)
        begin
            n_errors++;
            print_verdict;
        end
    endtask
    initial
    begin
        g = '{16'h3, 32'h2580, 16'h4, 16'h5, 16'h2, 16'h0, 16'hc, 16'h1000,
              16'h1, 16'h1, 16'h1, 16'h0};
        b = '{16'h3, 32'h4d2, 16'h5, 16'h4, 16'h0, 16'h4, 16'hd, 16'h1001,
              16'h0, 16'h0, 16'h0, 16'h0};
        repeat (2) @(negedge clk);
        rst_i = 1'b0;
        rd;
        chk({w[0], w[1]}, 0, "reset words");
        chk({w[2], w[3]}, 0, "reset counts");
        load(g);
        rd;
        chk(w[3], 16'h0000, "fault good");
        $display("test boundary config done");
        load(b);
        rd;
        chk(w[3], 16'h07fe, "fault bad");
        chk(eff.baud, 32'h2580, "baud");
        chk({eff.parity, eff.word_len, eff.stop_bits, eff.handshake},
            {3'h0, 4'h8, 2'h1, 2'h0}, "format");
        chk({eff.term_str_en, eff.pkt_len_en, eff.rx_tmo_en, eff.icd_en},
            4'h0, "enables");
        chk(eff.wr_tmo, 16'h1388, "wr tmo");
        cfg = g;
        rd;
        chk(w[3], 16'h07fe, "fault held");
        g.term_type = 16'h10;
        load(g);
        chk(eff.term_type, 4'h0, "term type");
        rd;
        chk(w[3], 16'h0001, "fault term");
        $display("test fault word done");
        g.term_type = 16'h3;
        load(g);
        send(16'h0002, 1'b1);
        rd;
        chk(w[0], 16'h0000, "tx phase");
        chk({w[1], w[2]}, {16'h2, 16'h1}, "tx counts");
        g.msg_dly = 16'h1;
        load(g);
        send(16'h0001, 1'b0);
        rd;
        chk(w[0], 16'h0065, "delay phase");
        send(16'h0000, 1'b1);
        g.msg_dly = 16'h0;
        g.handshake = 16'h1;
        load(g);
        send(16'h0001, 1'b0);
        chk(rts, 1'b1, "rts");
        rd;
        chk(w[0], 16'h0001, "rts phase");
        send(16'h0000, 1'b1);
        chk(rts, 1'b0, "rts off");
        rd;
        chk(w[0], 16'h0000, "tmo phase");
        chk({w[1], w[2]}, {16'h3, 16'h2}, "tmo counts");
        $display("test transmit done");
        @(negedge clk) rxb = 1'b1;
        @(negedge clk) rxb = 1'b0;
        @(negedge clk) rxb = 1'b1;
        @(negedge clk) rxb = 1'b0;
        chk(drp, 1'b1, "drop");
        rd;
        chk(w[3], 16'h8000, "overrun");
        load(g);
        rd;
        chk(w[3], 16'h0000, "overrun clear");
        $display("test overrun done");
        print_verdict;
    end
endmodule // serial_port_status_and_error_word_test
